// *** pkg/frps_regs.svh ***
// register offsets, control bit positions, unlock keys, reset values and timing
`ifndef FRPS_REGS_SVH
`define FRPS_REGS_SVH

`define FRPS_OFS_PTR_LOW 5'h00
`define FRPS_OFS_PTR_HIGH 5'h04
`define FRPS_OFS_PTR_UPPER 5'h08
`define FRPS_OFS_LATCH 5'h0C
`define FRPS_OFS_UNLOCK 5'h10
`define FRPS_OFS_CTRL 5'h14
`define FRPS_OFS_TBL_CMD 5'h18
`define FRPS_OFS_INT_CTRL 5'h1C

`define FRPS_BIT_ERASE_SEL 4
`define FRPS_BIT_FAULT 3
`define FRPS_BIT_ARM 2
`define FRPS_BIT_START 1
`define FRPS_BIT_CMD_WRITE 2

`define FRPS_KEY_FIRST 8'h55
`define FRPS_KEY_SECOND 8'hAA

`define FRPS_RST_BYTE 8'h00
`define FRPS_RST_PTR 22'h000000
`define FRPS_ROW_MASK 22'h3FFFC0
`define FRPS_BLOCK_MASK 22'h3FFC00

`define FRPS_CLK_PERIOD_NS 100
`define FRPS_CYCLE_TIME_US 2000
`define FRPS_CYCLE_CYCLES ((`FRPS_CYCLE_TIME_US * 1000) / `FRPS_CLK_PERIOD_NS)

`endif

// *** pkg/frps_pkg.sv ***
// types shared by the row program sequencer modules
`default_nettype none
package frps_pkg;

   typedef enum logic [1:0] {
      KEY_IDLE = 2'b00,
      KEY_GOT_FIRST = 2'b01,
      KEY_OPEN = 2'b10
   } frps_key_t;

   typedef enum logic [1:0] {
      TBL_KEEP = 2'b00,
      TBL_POST_INC = 2'b01,
      TBL_POST_DEC = 2'b10,
      TBL_PRE_INC = 2'b11
   } frps_tbl_mode_t;

   typedef struct packed {
      logic [21:0] ptr;
      logic [7:0] latch;
      logic [7:0] int_ctl;
      logic erase_sel;
      logic fault;
      logic arm;
      logic start;
      frps_key_t key;
      logic rd_pend;
      logic rd_done;
      logic [7:0] rdata;
      logic go_prog;
      logic go_erase;
      logic [21:0] row_addr;
   } frps_state_t;

   typedef struct packed {
      logic [63:0][7:0] mem;
      logic [7:0] rd_data;
   } frps_buf_state_t;

   typedef struct packed {
      logic busy;
      logic [23:0] cnt;
   } frps_tmr_state_t;

endpackage
`default_nettype wire

// *** pkg/frps_buf_if.sv ***
// holding buffer port between the sequencer and its buffer memory
`default_nettype none
interface frps_buf_if;
   logic wr_en;
   logic [5:0] wr_idx;
   logic [7:0] wr_data;
   logic [5:0] rd_idx;
   logic [7:0] rd_data;
   modport seq (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
   modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire

// *** design/frps_hold_buf.sv ***
// 64-byte holding buffer with a registered read port for the flash array
`default_nettype none
module frps_hold_buf (
   input wire logic clk_sys,
   input wire logic rst_n,
   frps_buf_if.mem bif
);
   import frps_pkg::*;

   frps_buf_state_t st_q, st_d;

   // contents survive a program cycle; only a table write changes them
   always_comb begin
      st_d = st_q;
      if (bif.wr_en) begin
         st_d.mem[bif.wr_idx] = bif.wr_data;
      end
      st_d.rd_data = st_q.mem[bif.rd_idx];
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign bif.rd_data = st_q.rd_data;

   AST_HOLD_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_n) // R17
      !bif.wr_en |=> st_q.mem == $past(st_q.mem))
      else $error("holding buffer changed without a table write");

endmodule // frps_hold_buf
`default_nettype wire

// *** design/frps_cycle_timer.sv ***
// long-write timer: busy for a fixed count of cycles, stopped early by abort
`include "frps_regs.svh"
`default_nettype none
module frps_cycle_timer #(
   parameter int unsigned CYCLES = `FRPS_CYCLE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic start,
   input wire logic abort,
   output logic busy,
   output logic done
);
   import frps_pkg::*;

   frps_tmr_state_t st_q, st_d;

   always_comb begin
      st_d = st_q;
      if (start && !st_q.busy) begin
         st_d.busy = 1'b1;
         st_d.cnt = 24'(CYCLES - 1);
      end else if (st_q.busy) begin
         if (abort || st_q.cnt == 24'h000000) begin
            st_d.busy = 1'b0;
         end else begin
            st_d.cnt = st_q.cnt - 24'h000001;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign busy = st_q.busy;
   // comb so the owner can end its cycle on the very last busy cycle
   assign done = st_q.busy && st_q.cnt == 24'h000000 && !abort;

endmodule // frps_cycle_timer
`default_nettype wire

// *** design/frps_top.sv ***
// flash row program sequencer: table pointer, holding buffer, unlock and long-write control
//
// Function
// R1: software fills all 64 buffer bytes first
// R2: pre-increment table write bumps pointer, stores latch
// R3: start ignored while program arm is clear
// R4: start accepted only after 55h then AAh
// R5: accepted start launches the flash cycle
// R6: cpu stalled for the timed 2 ms cycle
// R7: pointer must sit inside the buffered row
// R8: software erases a block before reprogramming
// R9: sixteen row loads fill one erase block
// R10: reset during cycle sets program fault
// R11: control bits 4..1, others read zero
// R12: unlock register stores nothing, reads zero
// R13: pointer split over three byte registers
// R14: software verifies by table reads afterwards
// R15: erase select plus arm erases instead
// R16: erase ignores pointer bits 9:0
// R17: holding buffer kept after a cycle
// R18: software masks interrupts around key writes
// R19: start reads set until timer ends cycle
// R20: software clears arm after each cycle
`include "frps_regs.svh"
`default_nettype none
module frps_top #(
   parameter int unsigned CYCLE_CYCLES = `FRPS_CYCLE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic external_reset_pin_evt,
   input wire logic watchdog_timer_evt,
   output logic cpu_stall,
   output logic flash_prog_go,
   output logic flash_erase_go,
   output logic [21:0] flash_row_addr,
   output logic [21:0] flash_rd_addr,
   input wire logic [7:0] flash_rd_data,
   input wire logic [5:0] flash_buf_idx,
   output logic [7:0] flash_buf_data
);
   import frps_pkg::*;

   frps_state_t st_q, st_d;
   frps_buf_if bif ();

   logic wr_ok;
   logic [7:0] wd;
   logic hit_unlock;
   logic hit_ctrl;
   logic hit_cmd;
   logic tbl_wr;
   logic tbl_rd;
   frps_tbl_mode_t mode;
   logic [21:0] ptr_inc;
   logic [21:0] ptr_dec;
   logic launch;
   logic abort_evt;
   logic tmr_done;
   logic [7:0] rd_mux;

   // only byte lane 0 carries register data
   assign wr_ok = avs_write && avs_byteenable[0];
   assign wd = avs_writedata[7:0];
   assign hit_unlock = avs_address == `FRPS_OFS_UNLOCK;
   assign hit_ctrl = avs_address == `FRPS_OFS_CTRL;
   assign hit_cmd = avs_address == `FRPS_OFS_TBL_CMD;
   assign tbl_wr = wr_ok && hit_cmd && wd[`FRPS_BIT_CMD_WRITE];
   assign tbl_rd = wr_ok && hit_cmd && !wd[`FRPS_BIT_CMD_WRITE];
   assign mode = frps_tbl_mode_t'(wd[1:0]);
   assign ptr_inc = st_q.ptr + 22'h000001;
   assign ptr_dec = st_q.ptr - 22'h000001;

   // a reset source only counts as a fault while a cycle is running
   assign abort_evt = st_q.start && (external_reset_pin_evt || watchdog_timer_evt);

   // start needs arm already set and the key pair just completed
   assign launch = wr_ok && hit_ctrl && wd[`FRPS_BIT_START] && !st_q.start
                   && st_q.arm && st_q.key == KEY_OPEN; // R3 R4 R5

   // buffer writes are short writes: no flash cycle, just the byte
   assign bif.wr_en = tbl_wr; // R2
   assign bif.wr_idx = (mode == TBL_PRE_INC) ? ptr_inc[5:0] : st_q.ptr[5:0]; // R2
   assign bif.wr_data = st_q.latch;
   assign bif.rd_idx = flash_buf_idx;
   assign flash_buf_data = bif.rd_data;

   frps_hold_buf u_buf (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .bif(bif)
   );

   frps_cycle_timer #(
      .CYCLES(CYCLE_CYCLES)
   ) u_tmr (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .start(launch),
      .abort(abort_evt),
      .busy(),
      .done(tmr_done)
   );

   always_comb begin
      rd_mux = 8'h00;
      case (avs_address)
         `FRPS_OFS_PTR_LOW: rd_mux = st_q.ptr[7:0]; // R13
         `FRPS_OFS_PTR_HIGH: rd_mux = st_q.ptr[15:8]; // R13
         `FRPS_OFS_PTR_UPPER: rd_mux = {2'h0, st_q.ptr[21:16]}; // R13
         `FRPS_OFS_LATCH: rd_mux = st_q.latch;
         `FRPS_OFS_CTRL: rd_mux = {3'h0, st_q.erase_sel, st_q.fault, st_q.arm,
                                   st_q.start, 1'b0}; // R11 R19
         `FRPS_OFS_INT_CTRL: rd_mux = st_q.int_ctl;
         // unlock, command and unmapped words read as zero
         default: rd_mux = 8'h00; // R12
      endcase
   end

   always_comb begin
      st_d = st_q;
      st_d.go_prog = 1'b0;
      st_d.go_erase = 1'b0;

      // read answer is registered, so a read waits one cycle, or two while a pre-increment table read is pending
      if (avs_read && !st_q.rd_done && !st_q.rd_pend) begin
         st_d.rd_done = 1'b1;
         st_d.rdata = rd_mux;
      end else begin
         st_d.rd_done = 1'b0;
      end

      if (st_q.rd_pend) begin
         st_d.latch = flash_rd_data;
         st_d.rd_pend = 1'b0;
      end

      if (wr_ok) begin
         // any write other than the key pair breaks the sequence, the start write included
         st_d.key = KEY_IDLE; // R4
         case (avs_address)
            `FRPS_OFS_PTR_LOW: st_d.ptr[7:0] = wd; // R13
            `FRPS_OFS_PTR_HIGH: st_d.ptr[15:8] = wd; // R13
            `FRPS_OFS_PTR_UPPER: st_d.ptr[21:16] = wd[5:0]; // R13
            `FRPS_OFS_LATCH: st_d.latch = wd;
            `FRPS_OFS_INT_CTRL: st_d.int_ctl = wd;
            `FRPS_OFS_UNLOCK: begin
               if (wd == `FRPS_KEY_FIRST) begin
                  st_d.key = KEY_GOT_FIRST; // R4
               end else if (wd == `FRPS_KEY_SECOND && st_q.key == KEY_GOT_FIRST) begin
                  st_d.key = KEY_OPEN; // R4
               end
            end
            `FRPS_OFS_CTRL: begin
               st_d.erase_sel = wd[`FRPS_BIT_ERASE_SEL]; // R11
               st_d.arm = wd[`FRPS_BIT_ARM]; // R11
               // software may clear the fault but never set it
               st_d.fault = st_q.fault && wd[`FRPS_BIT_FAULT]; // R10
            end
            `FRPS_OFS_TBL_CMD: begin
               case (mode)
                  TBL_POST_INC: st_d.ptr = ptr_inc;
                  TBL_POST_DEC: st_d.ptr = ptr_dec;
                  TBL_PRE_INC: st_d.ptr = ptr_inc; // R2
                  default: st_d.ptr = st_q.ptr;
               endcase
               if (tbl_rd) begin
                  // pre-increment read must wait for the new address to reach flash
                  if (mode == TBL_PRE_INC) begin
                     st_d.rd_pend = 1'b1;
                  end else begin
                     st_d.latch = flash_rd_data;
                  end
               end
            end
            default: st_d.ptr = st_q.ptr;
         endcase
      end

      if (launch) begin
         st_d.start = 1'b1; // R5 R19
         if (wd[`FRPS_BIT_ERASE_SEL]) begin
            st_d.go_erase = 1'b1; // R15
            st_d.row_addr = st_q.ptr & `FRPS_BLOCK_MASK; // R16
         end else begin
            st_d.go_prog = 1'b1; // R5
            st_d.row_addr = st_q.ptr & `FRPS_ROW_MASK; // R5
         end
      end

      if (tmr_done) begin
         st_d.start = 1'b0; // R6 R19
      end

      // set wins over a software clear in the same cycle
      if (abort_evt) begin
         st_d.start = 1'b0; // R10
         st_d.arm = 1'b0;
         st_d.fault = 1'b1; // R10
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         st_q.ptr <= `FRPS_RST_PTR;
         st_q.latch <= `FRPS_RST_BYTE;
         st_q.int_ctl <= `FRPS_RST_BYTE;
         st_q.key <= KEY_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   assign avs_waitrequest = avs_read && !st_q.rd_done;
   assign avs_readdata = {24'h000000, st_q.rdata};
   // the cpu sees the whole long write as one stall
   assign cpu_stall = st_q.start; // R6
   assign flash_prog_go = st_q.go_prog;
   assign flash_erase_go = st_q.go_erase;
   assign flash_row_addr = st_q.row_addr;
   assign flash_rd_addr = st_q.ptr;

   // ---------------- checks ----------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   logic [23:0] stall_cnt_q;
   logic aborted_q;
   // first key seen on the last write, with no other write since
   logic key1_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stall_cnt_q <= 24'h000000;
         aborted_q <= 1'b0;
         key1_q <= 1'b0;
      end else begin
         stall_cnt_q <= st_q.start ? stall_cnt_q + 24'h000001 : 24'h000000;
         aborted_q <= abort_evt;
         key1_q <= wr_ok ? (hit_unlock && wd == `FRPS_KEY_FIRST) : key1_q;
      end
   end

   sequence s_key_pair;
      key1_q && wr_ok && hit_unlock && wd == `FRPS_KEY_SECOND;
   endsequence

   sequence s_go_pulse;
      (flash_prog_go != flash_erase_go) ##1 !flash_prog_go && !flash_erase_go;
   endsequence

   sequence s_start_req;
      wr_ok && hit_ctrl && wd[`FRPS_BIT_START] && !st_q.start;
   endsequence

   property p_pair_opens;
      s_key_pair |=> st_q.key == KEY_OPEN;
   endproperty

   AST_KEY_PAIR: assert property (p_pair_opens) // R4
      else $error("key pair did not open the start gate");

   AST_NO_KEY_NO_START: assert property ( // R4
      s_start_req and (st_q.key != KEY_OPEN) |=> !st_q.start)
      else $error("start taken without the key pair");

   AST_NO_ARM_NO_START: assert property ( // R3
      s_start_req and !st_q.arm |=> !st_q.start && !flash_prog_go && !flash_erase_go)
      else $error("start taken with arm clear");

   AST_LAUNCH_GO: assert property ( // R5
      s_start_req and st_q.arm && st_q.key == KEY_OPEN
      |=> st_q.start ##0 s_go_pulse)
      else $error("launch did not give one go pulse");

   AST_STALL_LEN: assert property ( // R6
      $fell(st_q.start) && !aborted_q |-> $past(stall_cnt_q) == 24'(CYCLE_CYCLES - 1))
      else $error("long write stall length wrong");

   AST_FAULT_SET: assert property ( // R10
      abort_evt |=> st_q.fault && !st_q.start && !cpu_stall)
      else $error("interrupted cycle did not raise the fault");

   AST_CTRL_ZERO: assert property ( // R11
      avs_read && hit_ctrl && !avs_waitrequest |-> avs_readdata[7:5] == 3'h0
      && avs_readdata[0] == 1'b0 && avs_readdata[1] == $past(st_q.start))
      else $error("control read shows unimplemented bits");

   AST_UNLOCK_READ: assert property ( // R12
      avs_read && hit_unlock && !avs_waitrequest |-> avs_readdata == 32'h00000000)
      else $error("unlock register read not zero");

   AST_PRE_INC: assert property ( // R2
      tbl_wr && mode == TBL_PRE_INC |-> bif.wr_en && bif.wr_idx == ptr_inc[5:0]
      ##1 st_q.ptr == $past(ptr_inc) && !st_q.start)
      else $error("pre-increment table write misplaced");

   AST_ERASE_BLOCK: assert property ( // R15 R16
      flash_erase_go |-> flash_row_addr[9:0] == 10'h000 && cpu_stall)
      else $error("erase address not block aligned");

   AST_START_HOLD: assert property ( // R19
      st_q.start && !tmr_done && !abort_evt |=> st_q.start)
      else $error("start cleared before the timer ended");

   AST_PTR_UPPER: assert property ( // R13
      avs_read && avs_address == `FRPS_OFS_PTR_UPPER && !avs_waitrequest |-> avs_readdata[7:6] == 2'h0)
      else $error("pointer upper byte shows bits above 21");

   AST_SHORT_WRITE: assert property ( // R2
      tbl_wr && !st_q.start |=> !cpu_stall && !flash_prog_go && !flash_erase_go)
      else $error("table write started a flash cycle");

   AST_NO_RELAUNCH: assert property ( // R19
      st_q.start && !flash_prog_go && !flash_erase_go |=> !flash_prog_go && !flash_erase_go)
      else $error("running cycle was launched again");

   // a hung timer would never let the stall fall, so bound it while it runs
   AST_STALL_MAX: assert property ( // R6
      stall_cnt_q <= 24'(CYCLE_CYCLES))
      else $error("long write stall overran the timer");

   AST_KEY_BROKEN: assert property ( // R4
      wr_ok && !hit_unlock |=> st_q.key == KEY_IDLE)
      else $error("key sequence survived another write");

   AST_FAULT_STICKY: assert property ( // R10
      st_q.fault && !(wr_ok && hit_ctrl) |=> st_q.fault)
      else $error("program fault dropped without a control write");

   AST_CTRL_WRITE: assert property ( // R11
      wr_ok && hit_ctrl && !abort_evt |=> st_q.arm == $past(wd[`FRPS_BIT_ARM])
      && st_q.erase_sel == $past(wd[`FRPS_BIT_ERASE_SEL]))
      else $error("control write did not land in arm and erase select");

endmodule // frps_top
`default_nettype wire

// *** testbench/frps_top_tb.sv ***
// self-checking bench for the flash row program sequencer, driven over its register bus
`include "frps_regs.svh"
`default_nettype none
module frps_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // short cycle so a full program run stays small
   localparam int CC = 20;
   localparam logic [4:0] LOW = `FRPS_OFS_PTR_LOW;
   localparam logic [4:0] HIGH = `FRPS_OFS_PTR_HIGH;
   localparam logic [4:0] UPR = `FRPS_OFS_PTR_UPPER;
   localparam logic [4:0] LAT = `FRPS_OFS_LATCH;
   localparam logic [4:0] KEY = `FRPS_OFS_UNLOCK;
   localparam logic [4:0] CTL = `FRPS_OFS_CTRL;
   localparam logic [4:0] CMD = `FRPS_OFS_TBL_CMD;
   localparam logic [4:0] ICR = `FRPS_OFS_INT_CTRL;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic pin_evt = 1'b0;
   logic wdt_evt = 1'b0;
   logic cpu_stall;
   logic prog_go;
   logic erase_go;
   logic [21:0] row_addr;
   logic [21:0] rd_addr;
   logic [7:0] flash_rd_data = 8'h00;
   logic [5:0] flash_buf_idx = 6'h00;
   logic [7:0] flash_buf_data;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   int n;
   int np;
   int ne;
   logic [31:0] rv;
   logic [21:0] ra;

   frps_top #(.CYCLE_CYCLES(CC)) dut_u (
      .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .external_reset_pin_evt(pin_evt), .watchdog_timer_evt(wdt_evt), .cpu_stall(cpu_stall),
      .flash_prog_go(prog_go), .flash_erase_go(erase_go), .flash_row_addr(row_addr),
      .flash_rd_addr(rd_addr), .flash_rd_data(flash_rd_data),
      .flash_buf_idx(flash_buf_idx), .flash_buf_data(flash_buf_data)
   );

   always #50 clk_sys = ~clk_sys;

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // the whole sequence needs a few hundred cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         summarize();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   // request held until the rising edge that sees waitrequest low, released at that edge
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= 1'b1;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      avs_write <= 1'b0;
   endtask

   // read data taken at the same edge that sees waitrequest low
   task automatic rd(input logic [4:0] a);
      @(posedge clk_sys);
      avs_address <= a;
      avs_read <= 1'b1;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      rv = avs_readdata;
      avs_read <= 1'b0;
   endtask

   task automatic key(input logic [7:0] k1, input logic [7:0] k2);
      wr(KEY, k1);
      wr(KEY, k2);
   endtask

   // follows a long write from the launching edge until the stall drops
   task automatic run_cyc(input logic ep, input logic ee, input logic [21:0] er);
      n = 0;
      np = 0;
      ne = 0;
      ra = 22'h000000;
      @(negedge clk_sys);
      while (cpu_stall === 1'b1 && n < 200) begin
         n++;
         if (prog_go === 1'b1) np++;
         if (erase_go === 1'b1) ne++;
         if (prog_go === 1'b1 || erase_go === 1'b1) ra = row_addr;
         @(negedge clk_sys);
      end
      chk("stall length", n, (ep | ee) ? CC : 0);
      chk("program pulses", np, 32'(ep));
      chk("erase pulses", ne, 32'(ee));
      if (ep | ee) chk("row address", {10'h000, ra}, {10'h000, er});
   endtask

   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(CTL);
      chk("control reset", rv, 32'h00000000);
      wr(KEY, 8'h55);
      rd(KEY);
      chk("unlock readback", rv, 32'h00000000);
      wr(5'h02, 8'hFF);
      rd(5'h02);
      chk("unmapped readback", rv, 32'h00000000);
      wr(CTL, 8'hFF);
      rd(CTL);
      chk("control all ones", rv, 32'h00000014);
      wr(CTL, 8'h00);
      $display("test registers finished");

      wr(UPR, 8'hFF);
      rd(UPR);
      chk("pointer upper", rv, 32'h0000003F);
      wr(UPR, 8'h01);
      wr(HIGH, 8'h23);
      wr(LOW, 8'h3F);
      rd(HIGH);
      chk("pointer high", rv, 32'h00000023);
      // pre-increment lands the first byte at the row base
      for (int i = 0; i < 64; i++) begin
         wr(LAT, 8'(8'h30 + i));
         wr(CMD, 8'h07);
      end
      rd(LOW);
      chk("pointer low after fill", rv, 32'h0000007F);
      chk("pointer", {10'h000, rd_addr}, 32'h0001237F);
      $display("test buffer fill finished");

      wr(CTL, 8'h00);
      key(8'h55, 8'hAA);
      wr(CTL, 8'h02);
      run_cyc(1'b0, 1'b0, 22'h000000);
      wr(CTL, 8'h04);
      key(8'hAA, 8'h55);
      wr(CTL, 8'h06);
      run_cyc(1'b0, 1'b0, 22'h000000);
      wr(KEY, 8'h55);
      wr(LAT, 8'h00);
      wr(KEY, 8'hAA);
      wr(CTL, 8'h06);
      run_cyc(1'b0, 1'b0, 22'h000000);
      $display("test refused starts finished");

      // the block is erased before any of its rows is programmed
      wr(CTL, 8'h14);
      key(8'h55, 8'hAA);
      wr(CTL, 8'h16);
      run_cyc(1'b0, 1'b1, 22'h012000);
      $display("test erase finished");

      wr(CTL, 8'h04);
      wr(ICR, 8'h00);
      key(8'h55, 8'hAA);
      wr(CTL, 8'h06);
      run_cyc(1'b1, 1'b0, 22'h012340);
      wr(ICR, 8'h80);
      rd(ICR);
      chk("interrupt control", rv, 32'h00000080);
      rd(CTL);
      chk("control after program", rv, 32'h00000004);
      wr(CTL, 8'h00);
      rd(CTL);
      chk("control after arm clear", rv, 32'h00000000);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_sys);
         flash_buf_idx <= 6'(i * 63);
         @(posedge clk_sys);
         @(negedge clk_sys);
         chk("buffer byte", {24'h000000, flash_buf_data}, 32'(8'h30 + i * 63));
      end
      @(posedge clk_sys);
      flash_rd_data <= 8'hC3;
      wr(CMD, 8'h00);
      rd(LAT);
      chk("table read latch", rv, 32'h000000C3);
      wr(CMD, 8'h01);
      rd(LOW);
      chk("pointer after post-increment read", rv, 32'h00000080);
      wr(CMD, 8'h02);
      rd(LOW);
      chk("pointer after post-decrement read", rv, 32'h0000007F);
      @(posedge clk_sys);
      flash_rd_data <= 8'h5A;
      wr(CMD, 8'h03);
      rd(LAT);
      chk("pre-increment read latch", rv, 32'h0000005A);
      chk("pointer after pre-increment read", {10'h000, rd_addr}, 32'h00012380);
      $display("test program finished");

      // the reset pin first, then the watchdog
      for (int i = 0; i < 2; i++) begin
         wr(CTL, 8'h04);
         key(8'h55, 8'hAA);
         wr(CTL, 8'h06);
         rd(CTL);
         chk("control while running", rv, 32'h00000006);
         @(posedge clk_sys);
         pin_evt <= (i == 0);
         wdt_evt <= (i == 1);
         @(posedge clk_sys);
         pin_evt <= 1'b0;
         wdt_evt <= 1'b0;
         @(negedge clk_sys);
         chk("stall after abort", {31'h0, cpu_stall}, 32'h00000000);
         rd(CTL);
         chk("control after abort", rv, 32'h00000008);
         wr(CTL, 8'h00);
         rd(CTL);
         chk("control after clear", rv, 32'h00000000);
      end
      $display("test abort finished");
      summarize();
   end
endmodule // frps_top_tb
`default_nettype wire
